/* File: dca_regs.vh */
// register map, field positions, reset values and frame timing of the
// upstream d-channel arbiter; assumes a 32-bit axi4-lite register bus
`ifndef DCA_REGS_VH
`define DCA_REGS_VH

// register byte offsets
`define DCA_ADDR_CHEN      8'h00
`define DCA_ADDR_CHEN_SLV  8'h04
`define DCA_ADDR_SUSP_VAL  8'h08
`define DCA_ADDR_MODE      8'h0C
`define DCA_ADDR_STATE     8'h10
`define DCA_ADDR_STATUS    8'h14

// reset values
`define DCA_CHEN_RST       32'h0000_0000
`define DCA_SUSP_VAL_RST   8'h00
`define DCA_MODE_RST       32'h0000_0000

// arbiter mode register fields
`define DCA_MODE_CODING    0
`define DCA_MODE_CCM_EN    1
`define DCA_MODE_N_LO      8
`define DCA_MODE_N_HI      15

// state register fields
`define DCA_STATE_LO       5
`define DCA_STATE_HI       7

// status register fields
`define DCA_STAT_UFL       0

// grant state machine codes
`define DCA_ST_SUSP        3'h0
`define DCA_ST_FULL        3'h1
`define DCA_ST_EXPECT      3'h2
`define DCA_ST_RECV        3'h3
`define DCA_ST_LIMITED     3'h4

// hdlc clock mode that hands the receiver to the arbiter
`define DCA_CLK_MODE_ARB   2'h3

// subscriber bus frame layout: 8 slots of 32 bits, two d-bits per slot
`define DCA_D_BIT0         5'h18
`define DCA_D_BIT1         5'h19
`define DCA_FRAMES_PER_BYTE 2'h3
`define DCA_ONES_LIMIT     3'h7

// control channel codes
`define DCA_MR_AVAIL       1'h1
`define DCA_CI_AVAIL       4'h0

// axi responses
`define DCA_RESP_OKAY      2'h0
`define DCA_RESP_SLVERR    2'h2

`endif

/* File: dca_pin_sync.v */
// pin synchroniser for the subscriber bus: data clock, frame sync and data
// assumes all pins are asynchronous to aclk and dcl is much slower than aclk
`timescale 1ns/1ns
module dca_pin_sync (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       dcl,
  input  wire       fsc,
  input  wire [3:0] din,
  output reg        bit_tick,
  output reg        frame_start,
  output reg  [3:0] din_bit
);

  reg [5:0] meta;
  reg [5:0] sync;
  reg       dcl_prev;
  reg       fsc_prev;

  // two flops per pin; only the second stage feeds any logic
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta        <= 6'h00;
      sync        <= 6'h00;
      dcl_prev    <= 1'b0;
      fsc_prev    <= 1'b0;
      bit_tick    <= 1'b0;
      frame_start <= 1'b0;
      din_bit     <= 4'hF;
    end else begin
      meta     <= {din, fsc, dcl};
      sync     <= meta;
      dcl_prev <= sync[0];
      bit_tick <= sync[0] & ~dcl_prev;         // one pulse per rising data clock
      if (sync[0] & ~dcl_prev) begin
        fsc_prev    <= sync[1];
        frame_start <= sync[1] & ~fsc_prev;    // first bit time after frame sync rises
        din_bit     <= sync[5:2];
      end else begin
        frame_start <= 1'b0;
      end
    end
  end

endmodule // dca_pin_sync

/* File: dca_arbiter.v */
// upstream d-channel arbiter: grants one hdlc receiver to one of 32 subscriber
// d-channels (4 ports x 8 slots), with axi4-lite registers and control channel
// assumes hdlc receiver events are one-cycle pulses on aclk, bus pins are async
`timescale 1ns/1ns
`include "dca_regs.vh"
module dca_arbiter (
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // hdlc receiver side, same clock
  input  wire [1:0]  hdlc_clock_mode,
  input  wire        hdlc_rx_reset,
  input  wire        hdlc_frame_recog,
  input  wire        hdlc_end_of_frame,
  output reg         rx_strobe,
  output reg         rx_data,
  output reg         suspend_int,
  // subscriber bus pins
  input  wire        dcl,
  input  wire        fsc,
  input  wire [3:0]  sub_din,
  // control channel master
  output reg  [31:0] ctrl_override,
  output reg         ctrl_use_mr,
  output reg         ctrl_mr_value,
  output reg  [3:0]  ctrl_ci_value
);

  reg  [31:0] chen;
  reg  [31:0] chen_slv;
  reg  [7:0]  susp_val;
  reg  [31:0] mode;
  reg         ufl_flag;
  reg  [2:0]  state;
  reg  [4:0]  sel_chan;
  reg  [8:0]  susp_cnt;
  reg  [1:0]  byte_frames;
  reg  [7:0]  idle_frames;
  reg  [2:0]  ones_cnt;
  reg  [7:0]  bit_pos;
  reg  [7:0]  aw_addr;
  reg         aw_full;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_full;
  wire        bit_tick;
  wire        frame_start;
  wire [3:0]  din_bit;
  wire [7:0]  n_frames;
  wire        arb_mode;
  wire        dbit_time;
  wire [7:0]  cur_pos;
  wire [31:0] monitor;
  wire [3:0]  zero_hit;
  wire [4:0]  win_chan;
  wire        zero_any;
  wire        sel_bit;
  wire        sel_time;
  wire        wr_go;
  wire        ufl_event;
  wire [32:0] rd_dec_aw;
  wire [32:0] rd_dec_ar;

  // byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  // register read decode
  function [32:0] rd_decode;
    input [7:0] addr;
    begin
      case (addr)
        `DCA_ADDR_CHEN:     rd_decode = {1'b1, chen};
        `DCA_ADDR_CHEN_SLV: rd_decode = {1'b1, chen_slv};
        `DCA_ADDR_SUSP_VAL: rd_decode = {1'b1, 24'h00_0000, susp_val};
        `DCA_ADDR_MODE:     rd_decode = {1'b1, mode};
        `DCA_ADDR_STATE:    rd_decode = {1'b1, 24'h00_0000, state, sel_chan};
        `DCA_ADDR_STATUS:   rd_decode = {1'b1, 31'h0000_0000, ufl_flag};
        default:            rd_decode = {1'b0, 32'h0000_0000};
      endcase
    end
  endfunction

  dca_pin_sync u_sync (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .dcl         (dcl),
    .fsc         (fsc),
    .din         (sub_din),
    .bit_tick    (bit_tick),
    .frame_start (frame_start),
    .din_bit     (din_bit)
  );

  // frame position: slot number in bits 7:5, bit within the slot in 4:0
  assign cur_pos   = frame_start ? 8'h00 : bit_pos;
  assign dbit_time = bit_tick & ((cur_pos[4:0] == `DCA_D_BIT0) | (cur_pos[4:0] == `DCA_D_BIT1));
  assign arb_mode  = (hdlc_clock_mode == `DCA_CLK_MODE_ARB);
  assign n_frames  = mode[`DCA_MODE_N_HI:`DCA_MODE_N_LO];

  // limited selection narrows the watch to enable and slave enable
  assign monitor = (state == `DCA_ST_LIMITED) ? (chen & chen_slv) : chen;

  // per port zero detect in the current slot; channel address is {port, slot}
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_port
      assign zero_hit[p] = ~din_bit[p] & monitor[{p[1:0], cur_pos[7:5]}];
    end
  endgenerate

  assign zero_any = dbit_time & (|zero_hit);
  // all hits share one slot, so the lowest port is the lowest channel
  assign win_chan = zero_hit[0] ? {2'h0, cur_pos[7:5]} :
                    zero_hit[1] ? {2'h1, cur_pos[7:5]} :
                    zero_hit[2] ? {2'h2, cur_pos[7:5]} : {2'h3, cur_pos[7:5]};
  assign sel_time  = dbit_time & (cur_pos[7:5] == sel_chan[2:0]);
  assign sel_bit   = din_bit[sel_chan[4:3]];
  assign ufl_event = (state == `DCA_ST_EXPECT) & frame_start &
                     (byte_frames == `DCA_FRAMES_PER_BYTE) & (susp_cnt == 9'h000);

  // frame bit counter
  always @(posedge aclk) begin
    if (!aresetn)
      bit_pos <= 8'h00;
    else if (bit_tick)
      bit_pos <= cur_pos + 8'h01;
  end

  // grant state machine
  always @(posedge aclk) begin
    if (!aresetn) begin
      state       <= `DCA_ST_SUSP;
      sel_chan    <= 5'h00;
      chen_slv    <= 32'h0000_0000;
      susp_cnt    <= 9'h000;
      byte_frames <= 2'h0;
      idle_frames <= 8'h00;
      ones_cnt    <= 3'h0;
      suspend_int <= 1'b0;
    end else begin
      suspend_int <= 1'b0;
      if (frame_start)
        byte_frames <= byte_frames + 2'h1;
      if (!arb_mode) begin
        state <= `DCA_ST_SUSP;
      end else if (hdlc_rx_reset) begin
        state <= `DCA_ST_FULL;
      end else begin
        case (state)
          `DCA_ST_FULL, `DCA_ST_LIMITED: begin
            if (zero_any) begin
              state       <= `DCA_ST_EXPECT;
              sel_chan    <= win_chan;
              susp_cnt    <= {1'b0, susp_val};
              byte_frames <= 2'h0;
              ones_cnt    <= 3'h0;
              if (state == `DCA_ST_FULL)
                chen_slv <= chen;
            end else if (state == `DCA_ST_LIMITED && frame_start) begin
              if (idle_frames + 8'h01 >= n_frames) begin
                state <= `DCA_ST_FULL;
              end
              idle_frames <= idle_frames + 8'h01;
            end
          end
          `DCA_ST_EXPECT: begin
            if (ufl_event) begin
              state       <= `DCA_ST_SUSP;
              suspend_int <= 1'b1;
            end else if (hdlc_frame_recog) begin
              state <= `DCA_ST_RECV;
            end else if (sel_time) begin
              ones_cnt <= sel_bit ? ones_cnt + 3'h1 : 3'h0;
              if (sel_bit && ones_cnt == `DCA_ONES_LIMIT - 3'h1) begin
                chen_slv[sel_chan] <= 1'b0;
                idle_frames        <= 8'h00;
                state <= (n_frames == 8'h00) ? `DCA_ST_FULL : `DCA_ST_LIMITED;
              end
            end
          end
          `DCA_ST_RECV: begin
            if (hdlc_end_of_frame) begin
              chen_slv[sel_chan] <= 1'b0;
              idle_frames        <= 8'h00;
              state <= (n_frames == 8'h00) ? `DCA_ST_FULL : `DCA_ST_LIMITED;
            end
          end
          `DCA_ST_SUSP: begin
            state <= `DCA_ST_SUSP;
          end
          default: begin
            state <= `DCA_ST_SUSP;
          end
        endcase
      end
      // one decrement per four frames while a channel holds the receiver
      if ((state == `DCA_ST_EXPECT || state == `DCA_ST_RECV) && !zero_any &&
          frame_start && byte_frames == `DCA_FRAMES_PER_BYTE && susp_cnt != 9'h000)
        susp_cnt <= susp_cnt - 9'h001;
    end
  end

  // receive strobe and data path: only the granted channel feeds the receiver
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_strobe <= 1'b0;
      rx_data   <= 1'b1;
    end else begin
      rx_strobe <= (state == `DCA_ST_EXPECT || state == `DCA_ST_RECV) && arb_mode &&
                   !ufl_event && sel_time;
      if (sel_time)
        rx_data <= sel_bit;
    end
  end

  // control channel master; blocked channels fall back to control memory
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_override <= 32'h0000_0000;
      ctrl_use_mr   <= 1'b0;
      ctrl_mr_value <= `DCA_MR_AVAIL;
      ctrl_ci_value <= `DCA_CI_AVAIL;
    end else begin
      ctrl_use_mr   <= mode[`DCA_MODE_CODING];
      ctrl_mr_value <= `DCA_MR_AVAIL;
      ctrl_ci_value <= `DCA_CI_AVAIL;
      if (!mode[`DCA_MODE_CCM_EN])
        ctrl_override <= chen;
      else
        case (state)
          `DCA_ST_FULL:    ctrl_override <= chen;
          `DCA_ST_LIMITED: ctrl_override <= chen & chen_slv;
          `DCA_ST_EXPECT,
          `DCA_ST_RECV:    ctrl_override <= chen & (32'h0000_0001 << sel_chan);
          default:         ctrl_override <= 32'h0000_0000;
        endcase
    end
  end

  // axi write: address and data taken in either order, answered when both held
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign wr_go         = aw_full && w_full && !s_axi_bvalid;
  assign rd_dec_aw     = rd_decode(aw_addr);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DCA_RESP_OKAY;
      chen         <= `DCA_CHEN_RST;
      susp_val     <= `DCA_SUSP_VAL_RST;
      mode         <= `DCA_MODE_RST;
      ufl_flag     <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // sticky underflow flag; a clear in the same cycle as a new event loses
      if (wr_go && aw_addr == `DCA_ADDR_STATUS && w_strb[0] && w_data[`DCA_STAT_UFL])
        ufl_flag <= 1'b0;
      if (suspend_int)
        ufl_flag <= 1'b1;
      if (wr_go) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= rd_dec_aw[32] ? `DCA_RESP_OKAY : `DCA_RESP_SLVERR;
        case (aw_addr)
          `DCA_ADDR_CHEN:     chen     <= merge(chen, w_data, w_strb);
          `DCA_ADDR_SUSP_VAL: susp_val <= w_strb[0] ? w_data[7:0] : susp_val;
          `DCA_ADDR_MODE:     mode     <= merge(mode, w_data, w_strb) & 32'h0000_FF03;
          default:            chen     <= chen;
        endcase
      end
    end
  end

  // axi read: one outstanding read, data registered
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_dec_ar     = rd_decode(s_axi_araddr);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DCA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_dec_ar[31:0];
      s_axi_rresp  <= rd_dec_ar[32] ? `DCA_RESP_OKAY : `DCA_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dca_arbiter

/* File: dca_arbiter_sva.sv */
// concurrent checks on the ports of the upstream d-channel arbiter
// assumes one aclk domain with a synchronous active-low reset
`timescale 1ns/1ns
module dca_arbiter_sva (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  hdlc_clock_mode,
  input wire        hdlc_end_of_frame,
  input wire        rx_strobe,
  input wire        suspend_int,
  input wire [31:0] ctrl_override,
  input wire        ctrl_mr_value,
  input wire [3:0]  ctrl_ci_value
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // reset itself must quiet every answer, so this one is not disabled by it
  chk_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !rx_strobe && !suspend_int) else $error("outputs active after reset");
  chk_mode_off: assert property ((hdlc_clock_mode != 2'h3) [*2] |-> !rx_strobe)
    else $error("strobe outside clock mode 3");
  // a bit time is eight aclk cycles, so strobes can never be closer than that
  chk_strobe_pulse: assert property (rx_strobe |=> !rx_strobe [*6])
    else $error("strobe longer than one cycle");
  chk_grant_alone: assert property (rx_strobe |-> $onehot(ctrl_override))
    else $error("more than the granted channel available");
  chk_int_stops: assert property (suspend_int |=> (!suspend_int && !rx_strobe) [*8])
    else $error("strobe or interrupt after underflow");
  chk_eof_quiet: assert property (hdlc_end_of_frame |-> ##2 !rx_strobe [*4])
    else $error("strobe after end of frame");
  chk_avail_code: assert property ($past(aresetn) |-> ctrl_mr_value && !ctrl_ci_value[2])
    else $error("wrong available code");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");

  // main scenarios
  cov_strobe: cover property (rx_strobe);
  cov_underflow: cover property (suspend_int);
  cov_eof: cover property (hdlc_end_of_frame ##2 !rx_strobe);
endmodule // dca_arbiter_sva

bind dca_arbiter dca_arbiter_sva i_sva (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .hdlc_clock_mode,
  .hdlc_end_of_frame, .rx_strobe, .suspend_int, .ctrl_override, .ctrl_mr_value, .ctrl_ci_value);

/* File: dca_sub_bus.sv */
// subscriber bus model: free-running bit clock, frame sync and four data ports
// assumes zero_req selects channels {port,slot} that send a zero at d-bit 24
`timescale 1ns/1ns
module dca_sub_bus (
  input  wire [31:0] zero_req,
  output reg         dcl,
  output reg         fsc,
  output reg  [3:0]  sub_din
);
  reg [7:0] bit_no;
  integer   p;

  // data changes on the falling edge so the rising edge samples settled bits
  initial begin
    dcl = 1'b0;
    fsc = 1'b0;
    sub_din = 4'hf;
    bit_no = 8'hff;
    #37;
    forever begin
      #400 dcl = 1'b1;
      #400 dcl = 1'b0;
      bit_no = bit_no + 8'h01;
      fsc = (bit_no == 8'h00);
      for (p = 0; p < 4; p++)
        sub_din[p] = !(zero_req[{p[1:0], bit_no[7:5]}] && bit_no[4:0] == 5'h18);
    end
  end
endmodule // dca_sub_bus

/* File: tb_dca_arbiter.sv */
// bench of the upstream d-channel arbiter: register rows, then the grant walk
// assumes dca_sub_bus drives the subscriber pins and the bench plays the receiver
`timescale 1ns/1ns
module tb_dca_arbiter;
  typedef struct { logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [1:0] r; } dca_row_t;
  logic [7:0]  awaddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] zero_req = 32'h0000_0000;
  logic [31:0] rd_d;
  logic [1:0]  rd_r;
  logic [1:0]  clk_mode = 2'h0;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        rx_rst = 1'b0;
  logic        recog = 1'b0;
  logic        eof = 1'b0;
  wire  [31:0] rdata, ctrl_override;
  wire  [3:0]  din, ci_val;
  wire  [1:0]  bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid, rx_strobe, rx_data;
  wire         suspend_int, dcl, fsc, ctrl_use_mr, ctrl_mr_value;
  integer      failures = 0;
  integer      n_tests = 0;
  time         t0;
  // reset values; the unmapped row checks only its response
  dca_row_t rows [7] = '{'{8'h00, 32'h0, 32'hFFFF_FFFF, 2'h0}, '{8'h04, 32'h0, 32'hFFFF_FFFF, 2'h0},
    '{8'h08, 32'h0, 32'hFFFF_FFFF, 2'h0}, '{8'h0C, 32'h0, 32'hFFFF_FFFF, 2'h0},
    '{8'h10, 32'h0, 32'hFFFF_FFFF, 2'h0}, '{8'h14, 32'h0, 32'hFFFF_FFFF, 2'h0}, '{8'h20, 32'h0, 32'h0, 2'h2}};

  dca_arbiter i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hdlc_clock_mode(clk_mode),
    .hdlc_rx_reset(rx_rst), .hdlc_frame_recog(recog), .hdlc_end_of_frame(eof), .rx_strobe(rx_strobe),
    .rx_data(rx_data), .suspend_int(suspend_int), .dcl(dcl), .fsc(fsc), .sub_din(din),
    .ctrl_override(ctrl_override), .ctrl_use_mr(ctrl_use_mr), .ctrl_mr_value(ctrl_mr_value), .ctrl_ci_value(ci_val));
  dca_sub_bus i_bus (.zero_req(zero_req), .dcl(dcl), .fsc(fsc), .sub_din(din));

  // write: address and data offered together, each released when taken
  task automatic axi_wr(input [7:0] a, input [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rd_r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
  endtask
  task automatic cmp(input string n, input [31:0] e, input [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_cmp(input [7:0] a, input [31:0] m, input [31:0] e);
    axi_rd(a);
    cmp($sformatf("reg %h", a), e, rd_d & m);
  endtask
  // polls the state field; the poll gap is far shorter than any state lasts
  task automatic wait_st(input [2:0] s);
    integer k = 0;
    do begin
      repeat (20) @(posedge aclk);
      axi_rd(8'h10);
      k++;
    end while (rd_d[7:5] !== s && k < 1500);
    cmp("state wait", {29'h0, s}, {29'h0, rd_d[7:5]});
  endtask
  // receiver events: 0 reset, 1 frame recognised, 2 end of frame
  task automatic pulse(input [1:0] w);
    @(posedge aclk);
    {eof, recog, rx_rst} <= 3'h1 << w;
    @(posedge aclk);
    {eof, recog, rx_rst} <= 3'h0;
  endtask
  task automatic ws;
    do @(posedge aclk); while (rx_strobe !== 1'b1);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always #50 aclk = ~aclk;
  initial begin
    #8_000_000;
    failures++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      axi_rd(rows[i].a);
      cmp("reset value", rows[i].d, rd_d & rows[i].m);
      cmp("read resp", {30'h0, rows[i].r}, {30'h0, rd_r});
    end
    axi_wr(8'h20, 32'h0000_0001);
    cmp("write resp", 32'h0000_0002, {30'h0, rd_r});
    axi_wr(8'h10, 32'hFFFF_FFFF);
    rd_cmp(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    axi_wr(8'h00, 32'h0000_0404);
    axi_wr(8'h08, 32'h0000_0005);
    axi_wr(8'h0C, 32'h0000_0203);
    // receiver held in transparent mode 0, clock mode 3 on the switch
    clk_mode <= 2'h3;
    pulse(2'h0);
    rd_cmp(8'h10, 32'h0000_00E0, 32'h0000_0020);
    cmp("override", 32'h0000_0404, ctrl_override);
    cmp("coding", 32'h0000_0001, {31'h0, ctrl_use_mr});
    cmp("mr code", 32'h0000_0001, {31'h0, ctrl_mr_value});
    cmp("ci code", 32'h0000_0000, {31'h0, ci_val[2]});
    // ports 0 and 1 send a zero in the same bit time; channel 10 keeps on
    zero_req <= 32'h0000_0404;
    ws;
    zero_req <= 32'h0000_0400;
    rd_cmp(8'h10, 32'h0000_00FF, 32'h0000_0042);
    rd_cmp(8'h04, 32'hFFFF_FFFF, 32'h0000_0404);
    cmp("override", 32'h0000_0004, ctrl_override);
    repeat (3) begin
      ws;
      cmp("rx data", 32'h0000_0001, {31'h0, rx_data});
    end
    wait_st(3'h4);
    rd_cmp(8'h04, 32'hFFFF_FFFF, 32'h0000_0400);
    wait_st(3'h2);
    zero_req <= 32'h0000_0000;
    rd_cmp(8'h10, 32'h0000_00FF, 32'h0000_004A);
    rd_cmp(8'h04, 32'hFFFF_FFFF, 32'h0000_0400);
    pulse(2'h1);
    rd_cmp(8'h10, 32'h0000_00FF, 32'h0000_006A);
    pulse(2'h2);
    rd_cmp(8'h10, 32'h0000_00E0, 32'h0000_0080);
    rd_cmp(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
    wait_st(3'h1);
    axi_wr(8'h0C, 32'h0000_0002);
    zero_req <= 32'h0000_0400;
    ws;
    zero_req <= 32'h0000_0000;
    pulse(2'h1);
    pulse(2'h2);
    rd_cmp(8'h10, 32'h0000_00E0, 32'h0000_0020);
    cmp("coding", 32'h0000_0000, {31'h0, ctrl_use_mr});
    // a zero every frame keeps the ones count low, so only underflow can end it
    axi_wr(8'h08, 32'h0000_0000);
    zero_req <= 32'h0000_0004;
    ws;
    t0 = $time;
    do @(posedge aclk); while (suspend_int !== 1'b1);
    cmp("underflow late", 32'h0000_0000, {31'h0, ($time - t0) > 64'd822400});
    cmp("underflow early", 32'h0000_0000, {31'h0, ($time - t0) < 64'd614400});
    zero_req <= 32'h0000_0000;
    rd_cmp(8'h10, 32'h0000_00FF, 32'h0000_0002);
    rd_cmp(8'h14, 32'h0000_0001, 32'h0000_0001);
    axi_wr(8'h14, 32'h0000_0001);
    rd_cmp(8'h14, 32'h0000_0001, 32'h0000_0000);
    pulse(2'h0);
    rd_cmp(8'h10, 32'h0000_00E0, 32'h0000_0020);
    clk_mode <= 2'h2;
    rd_cmp(8'h10, 32'h0000_00E0, 32'h0000_0000);
    pulse(2'h0);
    rd_cmp(8'h10, 32'h0000_00E0, 32'h0000_0000);
    // suspended with the master on: control memory speaks for everyone
    cmp("override", 32'h0000_0000, ctrl_override);
    // master off: every enabled channel is available in any state
    axi_wr(8'h0C, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    cmp("override", 32'h0000_0404, ctrl_override);
    // reset in mid-run must bring back the suspended state and cleared registers
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_cmp(8'h10, 32'h0000_00FF, 32'h0000_0000);
    rd_cmp(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
    cmp("override", 32'h0000_0000, ctrl_override);
    wrap_up;
  end
endmodule // tb_dca_arbiter
